/* logic/hub_cfg_pkg.sv */
// hub_cfg_pkg: offsets, field positions and reset values of the hub identity/power config slice
// assumes a single sys_clk domain and a byte-wide register port driven by the eeprom/smbus loader
// Function
// - product id is 16 bits, low byte at 02h, high byte at 03h
// - release number is 16 bits bcd, low byte at 04h, high byte at 05h
// - registers load from serial eeprom or smbus slave writes
// - config byte 1 bit 7: 0 bus powered, 1 self powered
// - with dynamic power on, power state follows local supply pin, bit ignored
// - product id high byte forms upper half of reported product id
// - dynamic power enable lets hub switch power source automatically
package hub_cfg_pkg;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [7:0] OFS_PRODUCT_ID_LOW = 8'h02;
  localparam logic [7:0] OFS_PRODUCT_ID_HIGH = 8'h03;
  localparam logic [7:0] OFS_RELEASE_LOW = 8'h04;
  localparam logic [7:0] OFS_RELEASE_HIGH = 8'h05;
  localparam logic [7:0] OFS_HUB_CONFIG_FIRST = 8'h06;
  // ********************************
  // fields and reset values
  // ********************************
  localparam int POWER_SOURCE_SELECT_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'hBF;
  localparam logic [7:0] RESET_PRODUCT_ID_LOW = 8'h00;
  localparam logic [7:0] RESET_PRODUCT_ID_HIGH = 8'h00;
  localparam logic [7:0] RESET_RELEASE_LOW = 8'h00;
  localparam logic [7:0] RESET_RELEASE_HIGH = 8'h00;
  localparam logic [7:0] RESET_HUB_CONFIG_FIRST = 8'h00;
  localparam logic [7:0] RESET_READ_DATA = 8'h00;
endpackage

/* logic/hub_identity_power_config_regs.sv */
// hub_identity_power_config_regs: product id, release number and config byte 1 with power selection
// assumes the loader (eeprom reader or smbus slave) gives one-cycle byte strobes on sys_clk
`timescale 1ns/1ps
module hub_identity_power_config_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // byte register port from the loader
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // power control
  input wire logic dynamic_power_enable,
  input wire logic local_supply_present_pin,
  // reported values
  output logic [15:0] product_id,
  output logic [15:0] release_number,
  output logic self_powered
);
  import hub_cfg_pkg::*;

  logic [7:0] product_id_low_reg;
  logic [7:0] product_id_high_reg;
  logic [7:0] release_number_low_reg;
  logic [7:0] release_number_high_reg;
  logic [7:0] hub_config_first_reg;
  logic [7:0] hub_config_first_next;
  logic local_sync1_reg;
  logic local_sync2_reg;
  logic self_powered_reg;
  logic self_powered_next;
  logic [7:0] reg_rdata_reg;
  logic [7:0] reg_rdata_next;

  // ********************************
  // address decode
  // ********************************
  wire sel_pid_low = (reg_addr == OFS_PRODUCT_ID_LOW);
  wire sel_pid_high = (reg_addr == OFS_PRODUCT_ID_HIGH);
  wire sel_rel_low = (reg_addr == OFS_RELEASE_LOW);
  wire sel_rel_high = (reg_addr == OFS_RELEASE_HIGH);
  wire sel_cfg = (reg_addr == OFS_HUB_CONFIG_FIRST);
  assign reg_hit = sel_pid_low | sel_pid_high | sel_rel_low | sel_rel_high | sel_cfg;

  // ********************************
  // write strobes
  // ********************************
  // one strobe per register; an unmapped offset raises none, so its write is dropped
  wire wr_pid_low = reg_wr & sel_pid_low;
  wire wr_pid_high = reg_wr & sel_pid_high;
  wire wr_rel_low = reg_wr & sel_rel_low;
  wire wr_rel_high = reg_wr & sel_rel_high;
  wire wr_cfg = reg_wr & sel_cfg;

  // reserved bit masked
  // masking on the way in keeps bit 6 zero for read-back and any later decode
  assign hub_config_first_next = reg_wdata & CONFIG_WRITE_MASK;

  // ********************************
  // identity registers
  // ********************************
  // product id low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      product_id_low_reg <= RESET_PRODUCT_ID_LOW;
    end else if (wr_pid_low) begin
      product_id_low_reg <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      product_id_high_reg <= RESET_PRODUCT_ID_HIGH;
    end else if (wr_pid_high) begin
      product_id_high_reg <= reg_wdata;
    end
  end

  // release low byte
  // bcd digits are stored as given; the loader owns the encoding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      release_number_low_reg <= RESET_RELEASE_LOW;
    end else if (wr_rel_low) begin
      release_number_low_reg <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      release_number_high_reg <= RESET_RELEASE_HIGH;
    end else if (wr_rel_high) begin
      release_number_high_reg <= reg_wdata;
    end
  end

  // ********************************
  // configuration byte 1
  // ********************************
  // config byte store
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hub_config_first_reg <= RESET_HUB_CONFIG_FIRST;
    end else if (wr_cfg) begin
      hub_config_first_reg <= hub_config_first_next;
    end
  end

  // ********************************
  // read path
  // ********************************
  // read select, unmapped offsets read zero
  assign reg_rdata_next = sel_pid_low ? product_id_low_reg :
                          sel_pid_high ? product_id_high_reg :
                          sel_rel_low ? release_number_low_reg :
                          sel_rel_high ? release_number_high_reg :
                          sel_cfg ? hub_config_first_reg : 8'h00;

  // read data from a flop; costs one cycle of latency, keeps the port glitch free
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_reg <= RESET_READ_DATA;
    end else begin
      reg_rdata_reg <= reg_rdata_next;
    end
  end
  assign reg_rdata = reg_rdata_reg;

  assign product_id = {product_id_high_reg, product_id_low_reg};
  assign release_number = {release_number_high_reg, release_number_low_reg};

  // ********************************
  // power source selection
  // ********************************
  // pin is asynchronous; two flops before anything reads it
  // only the second flop is read, so a metastable first stage never reaches logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      local_sync1_reg <= 1'b0;
      local_sync2_reg <= 1'b0;
    end else begin
      local_sync1_reg <= local_supply_present_pin;
      local_sync2_reg <= local_sync1_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      self_powered_reg <= 1'b0;
    end else begin
      self_powered_reg <= self_powered_next;
    end
  end

  wire power_source_select = hub_config_first_reg[POWER_SOURCE_SELECT_BIT];
  assign self_powered_next = dynamic_power_enable ? local_sync2_reg : power_source_select;
  assign self_powered = self_powered_reg;

  // ********************************
  // assertions
  // ********************************
  // reserved bit zero
  a_reserved_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
    hub_config_first_reg[RESERVED_BIT] == 1'b0) else $error("reserved bit set");

  a_reserved_read_back: assert property (@(posedge sys_clk) disable iff (rst)
    sel_cfg |=> reg_rdata[RESERVED_BIT] == 1'b0) else $error("reserved bit read back set");

  a_pid_low_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && sel_pid_low |=> product_id[7:0] == $past(reg_wdata)) else $error("pid low not stored");

  a_pid_high_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && sel_pid_high |=> product_id[15:8] == $past(reg_wdata)) else $error("pid high not stored");

  a_pid_read_back: assert property (@(posedge sys_clk) disable iff (rst)
    sel_pid_high && !reg_wr |=> reg_rdata == product_id[15:8]) else $error("pid high read back wrong");

  a_rel_low_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && sel_rel_low |=> release_number[7:0] == $past(reg_wdata)) else $error("release low wrong");

  a_rel_high_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && sel_rel_high |=> release_number[15:8] == $past(reg_wdata)) else $error("release high wrong");

  a_cfg_loaded: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && sel_cfg |=> hub_config_first_reg == ($past(reg_wdata) & CONFIG_WRITE_MASK))
    else $error("config not loaded");

  a_unmapped_write_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && !reg_hit |=> $stable(product_id) && $stable(release_number) && $stable(hub_config_first_reg))
    else $error("unmapped write changed a register");

  a_static_power: assert property (@(posedge sys_clk) disable iff (rst)
    !dynamic_power_enable && !reg_wr |=> self_powered == $past(power_source_select))
    else $error("static power mode wrong");

  // pin selects self; pin to state takes three edges
  a_dynamic_power: assert property (@(posedge sys_clk) disable iff (rst)
    (dynamic_power_enable && local_supply_present_pin) [*3] |=> self_powered) else $error("dynamic self lost");

  a_dynamic_bus: assert property (@(posedge sys_clk) disable iff (rst)
    (dynamic_power_enable && !local_supply_present_pin) [*3] |=> !self_powered) else $error("dynamic bus lost");

  // main scenarios
  c_dynamic_switch: cover property (@(posedge sys_clk) disable iff (rst)
    dynamic_power_enable && $rose(self_powered));
  c_dynamic_drop: cover property (@(posedge sys_clk) disable iff (rst)
    dynamic_power_enable && $fell(self_powered));
  c_cfg_write: cover property (@(posedge sys_clk) disable iff (rst) reg_wr && sel_cfg);
  c_pid_both: cover property (@(posedge sys_clk) disable iff (rst)
    reg_wr && sel_pid_low ##1 reg_wr && sel_pid_high);
  c_unmapped_write: cover property (@(posedge sys_clk) disable iff (rst) reg_wr && !reg_hit);
endmodule // hub_identity_power_config_regs

/* tb/hub_cfg_loader_model.sv */
// loader model: plays the eeprom reader or smbus slave on the byte port
// assumes the slice shares sys_clk
`timescale 1ns/1ps
module hub_cfg_loader_model (
  // clock
  input wire logic sys_clk,
  // byte port toward the slice
  output logic reg_wr = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // stale data never looks valid
  endtask
  // address only, for reading back
  task automatic point(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
  endtask
endmodule // hub_cfg_loader_model

/* tb/test_hub_identity_power_config_regs.sv */
// bench: loads registers through the loader model and checks read-back and power state
// assumes 40 MHz sys_clk and synchronous reset
`timescale 1ns/1ps
module test_hub_identity_power_config_regs;
  import hub_cfg_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic dyn = 1'b0;
  logic pin = 1'b0;
  logic reg_wr, reg_hit, self_powered;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] product_id, release_number;
  int err_count = 0;
  int checks_done = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  hub_cfg_loader_model ldr_u (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  hub_identity_power_config_regs dut_u (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .dynamic_power_enable(dyn),
    .local_supply_present_pin(pin), .product_id(product_id), .release_number(release_number),
    .self_powered(self_powered));
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // read back one byte a cycle after pointing at it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    ldr_u.point(a);
    @(posedge sys_clk);
    #1;
    chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 2; i < 7; i++) begin
      rd(i[7:0], 8'h00);
    end
    ldr_u.wr(OFS_PRODUCT_ID_LOW, 8'h34);
    ldr_u.wr(OFS_PRODUCT_ID_HIGH, 8'h12);
    ldr_u.wr(OFS_RELEASE_LOW, 8'h01);
    ldr_u.wr(OFS_RELEASE_HIGH, 8'h02);
    rd(8'h03, 8'h12);
    chk("reg_hit", {15'h0000, reg_hit}, 16'h0001);
    chk("product_id", product_id, 16'h1234);
    chk("release_number", release_number, 16'h0201);
    ldr_u.wr(8'h07, 8'h55);
    rd(8'h07, 8'h00);
    chk("reg_hit", {15'h0000, reg_hit}, 16'h0000);
    ldr_u.wr(OFS_HUB_CONFIG_FIRST, 8'hFF);
    rd(8'h06, 8'hBF);
    chk("self_powered", {15'h0000, self_powered}, 16'h0001);
    // dynamic mode: pin low overrides the set bit
    @(posedge sys_clk);
    dyn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("self_powered", {15'h0000, self_powered}, 16'h0000);
    @(posedge sys_clk);
    pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("self_powered", {15'h0000, self_powered}, 16'h0001);
    @(posedge sys_clk);
    dyn <= 1'b0;
    ldr_u.wr(OFS_HUB_CONFIG_FIRST, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("self_powered", {15'h0000, self_powered}, 16'h0000);
    end_sim();
  end
  // watchdog, far beyond the roughly 50 cycles needed
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule // test_hub_identity_power_config_regs
